//--- hdl/bsp_dev.sv
// Device end: reset pin, start-up straps, pin defaults, rapid port, wake and host interrupt.
// Assumes the board wiring interface and a firmware register port on the same clock.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
module bsp_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  bsp_link_if.dev link,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  input wire logic odr_tick_i,
  input wire logic [15:0] an_pos_i,
  input wire logic [15:0] an_neg_i,
  output logic sys_rst_o,
  output logic boot_app_o,
  output logic spi_mode_o,
  output logic debug_state_o,
  output logic irq_o,
  output logic [2:0] irq_level_o
);
  localparam int SYNC_W = bsp_pkg::PIN_W + 2;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic rst_s;
  logic wake_s;
  logic [bsp_pkg::PIN_W-1:0] pin_s;

  always_ff @(posedge clk_i) begin
    meta_q <= {link.wake_pin, link.rst_lvl, link.io_lvl};
    sync_q <= meta_q;
  end
  assign pin_s = sync_q[bsp_pkg::PIN_W-1:0];
  assign rst_s = sync_q[bsp_pkg::PIN_W];
  assign wake_s = sync_q[bsp_pkg::PIN_W+1];

  // ****************************************
  // Reset and strap capture
  // ****************************************
  logic start_done_q;
  logic por_pend_q;
  logic cap_q;
  logic boot_app_q;
  logic spi_q;
  logic dbg_q;
  logic sys_rst;
  logic capture;

  // The pin only counts as a reset once start-up has seen it high, so a low
  // level at power-up selects ROM boot instead of holding the device in reset.
  assign sys_rst = rst_i | (start_done_q & ~rst_s);
  assign capture = cap_q & ~sys_rst;
  assign sys_rst_o = sys_rst;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_done_q <= 1'b0;
      por_pend_q <= 1'b1;
      boot_app_q <= bsp_pkg::STRAP_APP_RST;
    end else begin
      if (capture && por_pend_q) begin
        boot_app_q <= rst_s;
        por_pend_q <= 1'b0;
      end
      if (!por_pend_q && rst_s) begin
        start_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      cap_q <= 1'b1;
      spi_q <= bsp_pkg::STRAP_SPI_RST;
      dbg_q <= bsp_pkg::STRAP_DBG_RST;
    end else if (capture) begin
      // Held from here to the next reset whatever the pins do later.
      cap_q <= 1'b0;
      spi_q <= ~pin_s[bsp_pkg::PIN_SS];
      dbg_q <= ~pin_s[bsp_pkg::PIN_DBG];
    end
  end
  assign boot_app_o = boot_app_q;
  assign spi_mode_o = spi_q;
  assign debug_state_o = dbg_q;

  // ****************************************
  // Firmware registers
  // ****************************************
  logic [9:0] mux_q;
  logic [bsp_pkg::IO_W-1:0] io_dat_q;
  logic [bsp_pkg::IO_W-1:0] io_dir_q;
  logic [bsp_pkg::PIN_W-1:0] io_pu_q;
  logic [7:0] sys_q;
  logic [bsp_pkg::EV_W-1:0] ev_st_q;
  logic [bsp_pkg::EV_W-1:0] ev_en_q;
  logic [bsp_pkg::EV_W-1:0] ev_set;
  logic [bsp_pkg::EV_W-1:0] ev_clr;
  logic [15:0] diff_q;
  logic [bsp_pkg::IO_W-1:0] wv;

  assign wv = wdata_i[bsp_pkg::IO_W-1:0];

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      mux_q <= bsp_pkg::MUX_RST;
      io_dat_q <= '0;
      io_dir_q <= '0;
      io_pu_q <= '0;
      sys_q <= '0;
      ev_en_q <= '0;
    end else begin
      if (we_i) begin
        case (addr_i)
          bsp_pkg::DEV_MUX: mux_q <= wdata_i[9:0];
          bsp_pkg::DEV_IO_DATA: io_dat_q <= wv;
          bsp_pkg::DEV_IO_SET: io_dat_q <= io_dat_q | wv;
          bsp_pkg::DEV_IO_CLR: io_dat_q <= io_dat_q & ~wv;
          bsp_pkg::DEV_IO_TGL: io_dat_q <= io_dat_q ^ wv;
          bsp_pkg::DEV_IO_DIR: io_dir_q <= wv;
          bsp_pkg::DEV_IO_PULL: io_pu_q <= wdata_i[bsp_pkg::PIN_W-1:0];
          bsp_pkg::DEV_SYS: sys_q <= wdata_i[7:0];
          bsp_pkg::DEV_EV_EN: ev_en_q <= wdata_i[bsp_pkg::EV_W-1:0];
          default: ;
        endcase
      end
      // In I2C mode the strap pin becomes an ordinary port bit driving low.
      if (capture && pin_s[bsp_pkg::PIN_SS]) begin
        io_dir_q[bsp_pkg::PIN_SS] <= 1'b1;
        io_dat_q[bsp_pkg::PIN_SS] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Wake input, conversion and events
  // ****************************************
  logic wake_d_q;
  logic wake_hit;
  bsp_pkg::bsp_wake_t wake_mode;

  assign wake_mode = bsp_pkg::bsp_wake_t'(sys_q[bsp_pkg::SYS_WAKE_LSB +: 2]);

  always_comb begin
    case (wake_mode)
      bsp_pkg::BSP_WAKE_RISE: wake_hit = wake_s & ~wake_d_q;
      bsp_pkg::BSP_WAKE_FALL: wake_hit = ~wake_s & wake_d_q;
      bsp_pkg::BSP_WAKE_HIGH: wake_hit = wake_s;
      bsp_pkg::BSP_WAKE_LOW: wake_hit = ~wake_s;
      default: wake_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      wake_d_q <= 1'b0;
      diff_q <= '0;
    end else begin
      wake_d_q <= wake_s;
      // Sampled on the transducer data strobe so both paths share one rate.
      if (odr_tick_i) begin
        diff_q <= an_pos_i - an_neg_i;
      end
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[bsp_pkg::EV_WAKE] = wake_hit;
    ev_set[bsp_pkg::EV_ADC] = odr_tick_i;
    ev_clr = (we_i && addr_i == bsp_pkg::DEV_EV_CLR) ? wdata_i[bsp_pkg::EV_W-1:0] : '0;
  end

  // A new event in the same cycle as its clear stays set.
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      ev_st_q <= '0;
    end else begin
      ev_st_q <= (ev_st_q & ~ev_clr) | ev_set;
    end
  end

  assign irq_o = |(ev_st_q & ev_en_q);
  assign irq_level_o = (ev_st_q[bsp_pkg::EV_WAKE] & ev_en_q[bsp_pkg::EV_WAKE]) ?
                       bsp_pkg::WAKE_IRQ_LEVEL : 3'h0;

  // ****************************************
  // Pin drivers
  // ****************************************
  logic [bsp_pkg::PIN_W-1:0] pin_out_q;
  logic [bsp_pkg::PIN_W-1:0] pin_oe_q;
  logic rst_oe_q;
  logic int_q;

  for (genvar k = 0; k < bsp_pkg::PIN_W; k++) begin : g_pin
    logic gpio_en;
    logic route;
    // The strap pins keep their slave-select and debug roles while those are chosen, unless routing takes pin 9.
    assign gpio_en = mux_q[k] & ~(k == bsp_pkg::PIN_SS && spi_q) &
                     ~(k == bsp_pkg::PIN_DBG && dbg_q);
    if (k >= bsp_pkg::PIN_ROUTE_LO) begin : g_rt
      assign route = sys_q[bsp_pkg::SYS_ROUTE_LSB + k - bsp_pkg::PIN_ROUTE_LO];
    end else begin : g_nrt
      assign route = 1'b0;
    end
    always_ff @(posedge clk_i) begin
      if (sys_rst) begin
        pin_out_q[k] <= 1'b0;
        pin_oe_q[k] <= 1'b0;
      end else begin
        pin_out_q[k] <= route ? irq_o : io_dat_q[k];
        pin_oe_q[k] <= route | (gpio_en & io_dir_q[k]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      rst_oe_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      rst_oe_q <= sys_q[bsp_pkg::SYS_RSTDRV];
      int_q <= sys_q[bsp_pkg::SYS_CC];
    end
  end

  // The slave port pins are not gated by any sleep state of the processor side.
  assign link.dev_io_out = pin_out_q;
  assign link.dev_io_oe = pin_oe_q;
  assign link.dev_io_pu = io_pu_q;
  assign link.dev_rst_oe = rst_oe_q;
  assign link.int_pin = int_q;

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      rdata_o <= '0;
    end else if (re_i) begin
      case (addr_i)
        bsp_pkg::DEV_MUX: rdata_o <= {22'h0, mux_q};
        bsp_pkg::DEV_IO_DATA: rdata_o <= {16'h0, io_dat_q[bsp_pkg::IO_W-1:bsp_pkg::PIN_W], pin_s};
        bsp_pkg::DEV_IO_DIR: rdata_o <= {16'h0, io_dir_q};
        bsp_pkg::DEV_IO_PULL: rdata_o <= {22'h0, io_pu_q};
        bsp_pkg::DEV_SYS: rdata_o <= {24'h0, sys_q};
        bsp_pkg::DEV_BOOT: rdata_o <= {29'h0, dbg_q, spi_q, boot_app_q};
        bsp_pkg::DEV_EV_STAT: rdata_o <= {30'h0, ev_st_q};
        bsp_pkg::DEV_EV_EN: rdata_o <= {30'h0, ev_en_q};
        bsp_pkg::DEV_ADC: rdata_o <= {16'h0, diff_q};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule

//--- hdl/bsp_pkg.sv
// Shared constants for the boot strap and pin default logic and its host controller.
// Assumes one 250 MHz system clock shared by both ends.
package bsp_pkg;
  // ****************************************
  // Widths and pin positions
  // ****************************************
  localparam int IO_W = 16;
  localparam int PIN_W = 10;
  localparam int PIN_SS = 3;
  localparam int PIN_DBG = 9;
  localparam int PIN_ROUTE_LO = 6;
  localparam int ROUTE_W = 4;
  localparam int CNT_W = 24;
  // Pins 2..8 come out of reset as rapid port bits, pins 0, 1 and 9 do not.
  localparam logic [9:0] MUX_RST = 10'h1FC;
  localparam logic STRAP_SPI_RST = 1'b0;
  localparam logic STRAP_DBG_RST = 1'b0;
  localparam logic STRAP_APP_RST = 1'b1;
  localparam logic [2:0] WAKE_IRQ_LEVEL = 3'h7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_MS = 1000000;
  localparam int T_SS_HOLD_MS = 1;
  localparam int T_LAT_SLOW_MS = 33;
  localparam int T_LAT_FAST_MS = 2;
  localparam int T_RST_LOW_NS = 1000;
  localparam int CYC_SS_HOLD = (T_SS_HOLD_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_LAT_SLOW = (T_LAT_SLOW_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_LAT_FAST = (T_LAT_FAST_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_RST_LOW = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Device firmware register map
  // ****************************************
  localparam logic [7:0] DEV_MUX = 8'h00;
  localparam logic [7:0] DEV_IO_DATA = 8'h04;
  localparam logic [7:0] DEV_IO_SET = 8'h08;
  localparam logic [7:0] DEV_IO_CLR = 8'h0C;
  localparam logic [7:0] DEV_IO_TGL = 8'h10;
  localparam logic [7:0] DEV_IO_DIR = 8'h14;
  localparam logic [7:0] DEV_IO_PULL = 8'h18;
  localparam logic [7:0] DEV_SYS = 8'h1C;
  localparam logic [7:0] DEV_BOOT = 8'h20;
  localparam logic [7:0] DEV_EV_STAT = 8'h24;
  localparam logic [7:0] DEV_EV_CLR = 8'h28;
  localparam logic [7:0] DEV_EV_EN = 8'h2C;
  localparam logic [7:0] DEV_ADC = 8'h30;
  localparam int SYS_RSTDRV = 0;
  localparam int SYS_CC = 1;
  localparam int SYS_WAKE_LSB = 2;
  localparam int SYS_ROUTE_LSB = 4;
  localparam int EV_WAKE = 0;
  localparam int EV_ADC = 1;
  localparam int EV_W = 2;

  typedef enum logic [1:0] {
    BSP_WAKE_RISE = 2'h0,
    BSP_WAKE_FALL = 2'h1,
    BSP_WAKE_HIGH = 2'h2,
    BSP_WAKE_LOW = 2'h3
  } bsp_wake_t;

  // ****************************************
  // Host controller register map
  // ****************************************
  localparam logic [7:0] HST_CTRL = 8'h00;
  localparam logic [7:0] HST_CMD = 8'h04;
  localparam logic [7:0] HST_STAT = 8'h08;
  localparam logic [7:0] HST_CLR = 8'h0C;
  localparam logic [7:0] HST_EN = 8'h10;
  localparam logic [7:0] HST_STATE = 8'h14;
  localparam int CTRL_SPI = 0;
  localparam int CTRL_SLOW = 1;
  localparam int CTRL_WAKE = 2;
  localparam int CTRL_DBG = 3;
  localparam int CTRL_W = 4;
  localparam int CMD_HWRST = 0;
  localparam int CMD_HOLD = 1;
  localparam int HEV_DONE = 0;
  localparam int HEV_RESP = 1;
  localparam int HEV_DEVRST = 2;
  localparam int HEV_W = 3;

  typedef enum logic [3:0] {
    BSP_H_IDLE = 4'h1,
    BSP_H_RSTLOW = 4'h2,
    BSP_H_SSHOLD = 4'h4,
    BSP_H_CMDHOLD = 4'h8
  } bsp_hstate_t;
endpackage

//--- hdl/bsp_link_if.sv
// Board wiring between the sensor device and its host controller.
// Resolves the open-drain reset line and the shared pins from the drive enables.
`timescale 1ns/100ps
interface bsp_link_if;
  logic dev_rst_oe;
  logic host_rst_oe;
  logic rst_lvl;
  logic [bsp_pkg::PIN_W-1:0] dev_io_out;
  logic [bsp_pkg::PIN_W-1:0] dev_io_oe;
  logic [bsp_pkg::PIN_W-1:0] dev_io_pu;
  logic [bsp_pkg::PIN_W-1:0] io_lvl;
  logic host_ss_out;
  logic host_ss_oe;
  logic host_dbg_oe;
  logic int_pin;
  logic wake_pin;

  // Both ends only ever pull the reset line low; the weak pull-up wins otherwise.
  assign rst_lvl = ~(dev_rst_oe | host_rst_oe);

  always_comb begin
    for (int k = 0; k < bsp_pkg::PIN_W; k++) begin
      io_lvl[k] = dev_io_oe[k] ? dev_io_out[k] : dev_io_pu[k];
    end
    // Slave select pin has a board pull-up; the host and the device wire-AND on it.
    if (!dev_io_oe[bsp_pkg::PIN_SS]) begin
      io_lvl[bsp_pkg::PIN_SS] = 1'b1;
    end
    if (host_ss_oe) begin
      io_lvl[bsp_pkg::PIN_SS] = host_ss_out & io_lvl[bsp_pkg::PIN_SS];
    end
    // Debug strap has an internal pull-up; the host may only pull it low.
    if (!dev_io_oe[bsp_pkg::PIN_DBG]) begin
      io_lvl[bsp_pkg::PIN_DBG] = ~host_dbg_oe;
    end
  end

  modport dev (input rst_lvl, io_lvl, wake_pin,
               output dev_rst_oe, dev_io_out, dev_io_oe, dev_io_pu, int_pin);
  modport host (input rst_lvl, io_lvl, int_pin,
                output host_rst_oe, host_ss_out, host_ss_oe, host_dbg_oe, wake_pin);
endinterface

//--- hdl/bsp_host.sv
// Host controller end: drives the reset line and the slave select strap around resets.
// Assumes the board wiring interface and a software register port on the same clock.
`timescale 1ns/100ps
module bsp_host #(
  parameter int SS_HOLD_CYC = bsp_pkg::CYC_SS_HOLD,
  parameter int LAT_SLOW_CYC = bsp_pkg::CYC_LAT_SLOW,
  parameter int LAT_FAST_CYC = bsp_pkg::CYC_LAT_FAST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  bsp_link_if.host link,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  output logic irq_o
);
  if (SS_HOLD_CYC < 1 || LAT_SLOW_CYC < 1 || LAT_FAST_CYC < 1 ||
      SS_HOLD_CYC >= (1 << bsp_pkg::CNT_W) || LAT_SLOW_CYC >= (1 << bsp_pkg::CNT_W) ||
      LAT_FAST_CYC >= (1 << bsp_pkg::CNT_W)) begin : g_chk
    $error("bsp_host: hold counts must be 1 .. 2**CNT_W-1");
  end

  // ****************************************
  // Synchronisers
  // ****************************************
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic rst_s_d_q;
  logic int_s_d_q;

  always_ff @(posedge clk_i) begin
    meta_q <= {link.int_pin, link.rst_lvl};
    sync_q <= meta_q;
    rst_s_d_q <= sync_q[0];
    int_s_d_q <= sync_q[1];
  end

  // ****************************************
  // Registers and sequencer
  // ****************************************
  logic [bsp_pkg::CTRL_W-1:0] ctrl_q;
  logic [bsp_pkg::HEV_W-1:0] st_q;
  logic [bsp_pkg::HEV_W-1:0] en_q;
  logic [bsp_pkg::HEV_W-1:0] ev_set;
  logic [bsp_pkg::HEV_W-1:0] ev_clr;
  logic [bsp_pkg::CNT_W-1:0] cnt_q;
  logic cmd_wr;
  logic seq_done;
  bsp_pkg::bsp_hstate_t state_q;

  assign cmd_wr = we_i && addr_i == bsp_pkg::HST_CMD;
  assign seq_done = (state_q == bsp_pkg::BSP_H_SSHOLD || state_q == bsp_pkg::BSP_H_CMDHOLD)
                    && cnt_q == '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= '0;
      en_q <= '0;
    end else if (we_i) begin
      if (addr_i == bsp_pkg::HST_CTRL) begin
        ctrl_q <= wdata_i[bsp_pkg::CTRL_W-1:0];
      end
      if (addr_i == bsp_pkg::HST_EN) begin
        en_q <= wdata_i[bsp_pkg::HEV_W-1:0];
      end
    end
  end

  // Commands that arrive while a sequence runs are ignored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= bsp_pkg::BSP_H_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        bsp_pkg::BSP_H_IDLE: begin
          if (cmd_wr && wdata_i[bsp_pkg::CMD_HWRST]) begin
            state_q <= bsp_pkg::BSP_H_RSTLOW;
            cnt_q <= bsp_pkg::CNT_W'(bsp_pkg::CYC_RST_LOW - 1);
          end else if (cmd_wr && wdata_i[bsp_pkg::CMD_HOLD]) begin
            // Select goes low right after the command write and covers the latency.
            state_q <= bsp_pkg::BSP_H_CMDHOLD;
            cnt_q <= ctrl_q[bsp_pkg::CTRL_SLOW] ? bsp_pkg::CNT_W'(LAT_SLOW_CYC - 1) :
                     bsp_pkg::CNT_W'(LAT_FAST_CYC - 1);
          end
        end
        bsp_pkg::BSP_H_RSTLOW: begin
          if (cnt_q == '0) begin
            state_q <= bsp_pkg::BSP_H_SSHOLD;
            cnt_q <= bsp_pkg::CNT_W'(SS_HOLD_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        bsp_pkg::BSP_H_SSHOLD, bsp_pkg::BSP_H_CMDHOLD: begin
          if (cnt_q == '0) begin
            state_q <= bsp_pkg::BSP_H_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= bsp_pkg::BSP_H_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  logic rst_oe_q;
  logic ss_oe_q;
  logic ss_out_q;
  logic dbg_oe_q;
  logic wake_q;

  // In I2C mode the board pull-up keeps the strap high; in SPI mode the host
  // drives it, low through every reset and hold so the device reboots into SPI.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_oe_q <= 1'b0;
      ss_oe_q <= 1'b0;
      ss_out_q <= 1'b1;
      dbg_oe_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      rst_oe_q <= state_q == bsp_pkg::BSP_H_RSTLOW;
      ss_oe_q <= ctrl_q[bsp_pkg::CTRL_SPI];
      ss_out_q <= state_q == bsp_pkg::BSP_H_IDLE;
      dbg_oe_q <= ctrl_q[bsp_pkg::CTRL_DBG];
      wake_q <= ctrl_q[bsp_pkg::CTRL_WAKE];
    end
  end
  assign link.host_rst_oe = rst_oe_q;
  assign link.host_ss_oe = ss_oe_q;
  assign link.host_ss_out = ss_out_q;
  assign link.host_dbg_oe = dbg_oe_q;
  assign link.wake_pin = wake_q;

  // ****************************************
  // Events and read port
  // ****************************************
  always_comb begin
    ev_set = '0;
    ev_set[bsp_pkg::HEV_DONE] = seq_done;
    ev_set[bsp_pkg::HEV_RESP] = sync_q[1] & ~int_s_d_q;
    // Only a reset the host did not cause itself counts as a device reset.
    ev_set[bsp_pkg::HEV_DEVRST] = ~sync_q[0] & rst_s_d_q &
      (state_q == bsp_pkg::BSP_H_IDLE || state_q == bsp_pkg::BSP_H_CMDHOLD);
    ev_clr = (we_i && addr_i == bsp_pkg::HST_CLR) ? wdata_i[bsp_pkg::HEV_W-1:0] : '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= (st_q & ~ev_clr) | ev_set;
    end
  end
  assign irq_o = |(st_q & en_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      case (addr_i)
        bsp_pkg::HST_CTRL: rdata_o <= {28'h0, ctrl_q};
        bsp_pkg::HST_STAT: rdata_o <= {29'h0, st_q};
        bsp_pkg::HST_EN: rdata_o <= {29'h0, en_q};
        bsp_pkg::HST_STATE: rdata_o <= {26'h0, sync_q, state_q};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule

//--- tb/bsp_asserts.sv
// Checker on the board link between the device and the host controller.
// Assumes the bench clock and the power-on reset shared by both ends.
`timescale 1ns/100ps
module bsp_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dev_rst_oe,
  input wire logic host_rst_oe,
  input wire logic rst_lvl,
  input wire logic [9:0] dev_io_out,
  input wire logic [9:0] dev_io_oe,
  input wire logic [9:0] dev_io_pu,
  input wire logic [9:0] io_lvl,
  input wire logic host_ss_out,
  input wire logic int_pin
);
  logic [15:0] low_cnt_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // The host pulse is far too long for a repetition, so its length is counted.
  always_ff @(posedge clk_i) begin
    if (rst_i || !host_rst_oe) begin
      low_cnt_q <= 16'h0000;
    end else begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  rst_idle_a: assert property ($past(rst_i) |-> dev_io_oe == 10'h000
    && dev_io_pu == 10'h000 && !dev_rst_oe && !int_pin) else $error("link busy after reset");
  self_pulse_a: assert property ($rose(dev_rst_oe) |-> ##[1:6] !dev_rst_oe)
    else $error("device reset drive does not end");
  host_low_a: assert property ($fell(host_rst_oe) |-> low_cnt_q == 16'h00FA)
    else $error("host reset pulse length wrong");
  ss_under_a: assert property (host_rst_oe |-> !host_ss_out)
    else $error("select high while reset line held");
  ss_after_a: assert property ($fell(host_rst_oe) |-> !host_ss_out [*8])
    else $error("select released too soon after reset");
  i2c_free_a: assert property ($fell(rst_i) && io_lvl[3] |-> ##[1:3]
    dev_io_oe[3] && !dev_io_out[3]) else $error("strap pin not driven low in i2c mode");
  spi_keep_a: assert property ($rose(rst_lvl) && !io_lvl[3] |-> !dev_io_oe[3] [*8])
    else $error("device drives select pin in spi mode");
  pin_rst_a: assert property (!rst_lvl [*5] |-> dev_io_oe == 10'h000
    && dev_io_pu == 10'h000) else $error("pin reset does not clear pins");
endmodule

//--- tb/test_boot_strap_and_pin_defaults.sv
// Bench joining the device and host ends over the board link, with self-checks.
// Assumes one 250 MHz clock for both ends and the shortened host hold counts below.
`timescale 1ns/100ps
module test_boot_strap_and_pin_defaults;
  localparam int SS_HOLD = 20;
  localparam int LAT_SLOW = 40;
  localparam int LAT_FAST = 10;
  logic clk_i, rst_i, d_we, d_re, h_we, h_re, odr, app, spi, dbg, d_irq, h_irq, srst;
  logic [7:0] addr;
  logic [31:0] wdat, d_rd, h_rd, rd;
  logic [15:0] an_p, an_n;
  logic [2:0] lvl;
  int error_cnt, checks, dat, r, k, m;
  bsp_link_if link ();
  bsp_dev bsp_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link.dev), .addr_i(addr),
    .wdata_i(wdat), .we_i(d_we), .re_i(d_re), .rdata_o(d_rd), .odr_tick_i(odr),
    .an_pos_i(an_p), .an_neg_i(an_n), .sys_rst_o(srst), .boot_app_o(app), .spi_mode_o(spi),
    .debug_state_o(dbg), .irq_o(d_irq), .irq_level_o(lvl));
  bsp_host #(.SS_HOLD_CYC(SS_HOLD), .LAT_SLOW_CYC(LAT_SLOW), .LAT_FAST_CYC(LAT_FAST))
    bsp_host_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link.host), .addr_i(addr),
    .wdata_i(wdat), .we_i(h_we), .re_i(h_re), .rdata_o(h_rd), .irq_o(h_irq));
  bsp_asserts bsp_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .dev_rst_oe(link.dev_rst_oe),
    .host_rst_oe(link.host_rst_oe), .rst_lvl(link.rst_lvl), .dev_io_out(link.dev_io_out),
    .dev_io_oe(link.dev_io_oe), .dev_io_pu(link.dev_io_pu), .io_lvl(link.io_lvl),
    .host_ss_out(link.host_ss_out), .int_pin(link.int_pin));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One register access on either end; read data are taken in the cycle after the strobe.
  task automatic bus(input bit h, input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdat <= d;
    h_we <= h && w;
    h_re <= h && !w;
    d_we <= !h && w;
    d_re <= !h && !w;
    @(posedge clk_i);
    {h_we, h_re, d_we, d_re} <= 4'h0;
    @(negedge clk_i);
    rd = h ? h_rd : d_rd;
  endtask
  task automatic rc(input bit h, input logic [7:0] a, input logic [31:0] e, input string n);
    bus(h, 1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  task automatic wait_done();
    k = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1) begin
      bus(1'b1, 1'b0, bsp_pkg::HST_STAT, 32'h0);
      k++;
      if (k > 400) begin
        error_cnt++;
        report_and_stop();
      end
    end
  endtask
  initial begin
    rst_i = 1'b1;
    {d_we, d_re, h_we, h_re, odr} = 5'h00;
    addr = 8'h00;
    wdat = 32'h0;
    {an_p, an_n} = 32'h0;
    void'($urandom(32'h610F074F));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rc(0, bsp_pkg::DEV_MUX, 32'h1FC, "mux");
    rc(0, bsp_pkg::DEV_IO_DIR, 32'h8, "dir");
    rc(0, bsp_pkg::DEV_IO_PULL, 32'h0, "pull");
    rc(0, bsp_pkg::DEV_BOOT, 32'h1, "boot");
    rc(0, 8'hFC, 32'h0, "unmapped");
    chk("i2c pin", 32'({link.dev_io_oe[3], link.io_lvl[3]}), 32'h2);
    bus(0, 1, bsp_pkg::DEV_MUX, 32'h3FF);
    bus(0, 1, bsp_pkg::DEV_IO_DIR, 32'h3FF);
    dat = 0;
    for (m = 0; m < 8; m++) begin
      r = $urandom & 32'hFFFF;
      bus(0, 1, bsp_pkg::DEV_IO_DATA + 8'(4 * (m % 4)), 32'(r));
      case (m % 4)
        0: dat = r;
        1: dat |= r;
        2: dat &= ~r;
        default: dat ^= r;
      endcase
      repeat (4) @(posedge clk_i);
      rc(0, bsp_pkg::DEV_IO_DATA, 32'(dat), "port");
    end
    @(posedge clk_i);
    an_p <= 16'($urandom);
    an_n <= 16'($urandom);
    odr <= 1'b1;
    @(posedge clk_i);
    odr <= 1'b0;
    bus(0, 0, bsp_pkg::DEV_ADC, 32'h0);
    chk("adc", 32'(rd[15:0]), 32'(16'(an_p - an_n)));
    rc(0, bsp_pkg::DEV_EV_STAT, 32'h2, "odr event");
    bus(0, 1, bsp_pkg::DEV_EV_EN, 32'h1);
    // Each trigger mode is primed at the inactive level, cleared, then fired.
    for (m = 0; m < 4; m++) begin
      k = (m == 0 || m == 2) ? 1 : 0;
      bus(1, 1, bsp_pkg::HST_CTRL, 32'((1 - k) << bsp_pkg::CTRL_WAKE));
      bus(0, 1, bsp_pkg::DEV_SYS, 32'h0F0 | 32'(m << 2));
      repeat (4) @(posedge clk_i);
      bus(0, 1, bsp_pkg::DEV_EV_CLR, 32'h3);
      rc(0, bsp_pkg::DEV_EV_STAT, 32'h0, "wake idle");
      bus(1, 1, bsp_pkg::HST_CTRL, 32'(k << bsp_pkg::CTRL_WAKE));
      repeat (4) @(posedge clk_i);
      rc(0, bsp_pkg::DEV_EV_STAT, 32'h1, "wake hit");
      chk("irq", 32'({link.io_lvl[9:6], d_irq, lvl}), 32'hFF);
    end
    bus(0, 1, bsp_pkg::DEV_EV_EN, 32'h0);
    chk("masked", 32'({d_irq, lvl}), 32'h0);
    bus(1, 1, bsp_pkg::HST_EN, 32'h2);
    bus(0, 1, bsp_pkg::DEV_SYS, 32'h2);
    repeat (4) @(posedge clk_i);
    // The status bit lands on the fourth edge, so look once it has settled.
    @(negedge clk_i);
    chk("resp irq", 32'({link.int_pin, h_irq}), 32'h3);
    bus(0, 1, bsp_pkg::DEV_SYS, 32'h0);
    bus(1, 1, bsp_pkg::HST_CLR, 32'h7);
    chk("resp clr", 32'(h_irq), 32'h0);
    for (m = 1; m >= 0; m--) begin
      bus(1, 1, bsp_pkg::HST_CTRL, m ? 32'h9 : 32'h0);
      bus(1, 1, bsp_pkg::HST_CMD, 32'h1);
      wait_done();
      chk("reset seen", 32'(rd[2:0]), 32'h1);
      bus(1, 1, bsp_pkg::HST_CLR, 32'h7);
      rc(0, bsp_pkg::DEV_BOOT, m ? 32'h7 : 32'h1, "boot");
      chk("boot pins", 32'({dbg, spi, app}), m ? 32'h7 : 32'h1);
      rc(0, bsp_pkg::DEV_MUX, 32'h1FC, "mux");
    end
    for (m = 0; m < 2; m++) begin
      bus(1, 1, bsp_pkg::HST_CTRL, 32'h1 | 32'(m << 1));
      bus(1, 1, bsp_pkg::HST_CMD, 32'h2);
      k = 0;
      repeat (60) begin
        @(negedge clk_i);
        k += int'(link.host_ss_out === 1'b0);
      end
      chk("hold", 32'(k), m ? 32'(LAT_SLOW) : 32'(LAT_FAST));
      wait_done();
      bus(1, 1, bsp_pkg::HST_CLR, 32'h7);
    end
    // Command-induced reset: the device pulses its own reset line while the host holds
    // select low, so it must come back in SPI mode and the host must flag the reset.
    bus(1, 1, bsp_pkg::HST_CMD, 32'h2);
    bus(0, 1, bsp_pkg::DEV_SYS, 32'h1);
    k = 0;
    repeat (10) begin
      @(negedge clk_i);
      k += int'(srst === 1'b1);
    end
    chk("sys rst", 32'(k), 32'h3);
    wait_done();
    chk("device reset", 32'(rd[2:0]), 32'h5);
    bus(1, 1, bsp_pkg::HST_CLR, 32'h7);
    rc(0, bsp_pkg::DEV_BOOT, 32'h3, "cmd boot");
    report_and_stop();
  end
endmodule
